//--- src/wdtrf_top.v
// Watchdog timer with safety levels, timed unlock and reset-cause flags.
// Assumes an APB master on clk, and reset-cause inputs synchronous to clk.
`timescale 1ns/100ps
`include "wdtrf_consts.vh"

module wdtrf_top #(
    parameter integer SYS_HZ = `WDTRF_SYS_HZ,
    parameter integer OSC_HZ = `WDTRF_OSC_HZ
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        wdAlwaysOnFuse,
    input  wire        wdRestartInstruction,
    input  wire        globalIrqEnable,
    input  wire        wdIrqAck,
    input  wire        poweronReset,
    input  wire        brownoutReset,
    input  wire        externalReset,
    output reg         wdResetPulse_ff,
    output wire        wdIrq
);
    // ----------------------------------------------------------------
    // Fuse synchronisation and bus decode
    // ----------------------------------------------------------------
    reg        fuseMeta_ff;
    reg        fuseSync_ff;
    reg        wdEnableBit_ff;
    reg        wdIrqEnable_ff;
    reg        wdTimeoutFlag_ff;
    reg        wdChangeUnlock_ff;
    reg  [2:0] unlockCnt_ff;
    reg  [3:0] wdPeriodSelect_ff;
    reg        wdResetCauseFlag_ff;
    reg        brownoutCauseFlag_ff;
    reg        externalCauseFlag_ff;
    reg        poweronCauseFlag_ff;
    reg        nxt_en;
    reg        nxt_ie;
    reg  [3:0] nxt_per;
    wire       levelTwo;
    wire       wrCycle;
    wire       wrCtrl;
    wire       wrStat;
    wire       timeout;
    wire       tick;
    wire       chipReset;
    wire       enRead;
    wire [3:0] wrPer;
    wire       addrOk;

    // Fuse is a pin level, so it passes two flip-flops first
    always @(posedge clk) begin
        if (!rst_n) begin
            fuseMeta_ff <= 1'b0;
            fuseSync_ff <= 1'b0;
        end else begin
            fuseMeta_ff <= wdAlwaysOnFuse;
            fuseSync_ff <= fuseMeta_ff;
        end
    end

    assign levelTwo = fuseSync_ff;
    assign wrCycle  = psel && penable && pwrite;
    assign wrCtrl   = wrCycle && (paddr == `WDTRF_CTRL_ADDR);
    assign wrStat   = wrCycle && (paddr == `WDTRF_STAT_ADDR);
    assign addrOk   = (paddr == `WDTRF_CTRL_ADDR) || (paddr == `WDTRF_STAT_ADDR) ||
                      (paddr == `WDTRF_STRAP_ADDR);
    // Zero wait states; unmapped addresses answer with an error
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addrOk;
    assign wrPer    = {pwdata[`WDTRF_C_P3], pwdata[2:0]};
    assign chipReset = poweronReset || brownoutReset || externalReset || wdResetPulse_ff;

    // ----------------------------------------------------------------
    // Oscillator and counter
    // ----------------------------------------------------------------
    wdtrf_osc_tick #(
        .SYS_HZ (SYS_HZ),
        .OSC_HZ (OSC_HZ)
    ) uOsc (
        .clk     (clk),
        .rst_n   (rst_n),
        .tick_ff (tick)
    );

    wdtrf_counter #(
        .CNT_W (21)
    ) uCnt (
        .clk        (clk),
        .rst_n      (rst_n),
        .tick       (tick),
        .clear      (wdRestartInstruction || chipReset),
        .run        (wdEnableBit_ff || wdIrqEnable_ff),
        .periodSel  (wdPeriodSelect_ff),
        .timeout_ff (timeout)
    );

    // ----------------------------------------------------------------
    // Control register next state
    // ----------------------------------------------------------------
    // Unlock only matters for clearing enable and, at level two, changing the period
    always @* begin
        nxt_en  = wdEnableBit_ff;
        nxt_ie  = wdIrqEnable_ff;
        nxt_per = wdPeriodSelect_ff;
        if (wrCtrl) begin
            nxt_ie = pwdata[`WDTRF_C_IE];
            if (pwdata[`WDTRF_C_EN]) begin
                nxt_en = 1'b1;
            end else if (wdChangeUnlock_ff) begin
                nxt_en = 1'b0;
            end
            if (!levelTwo || wdChangeUnlock_ff) begin
                nxt_per = wrPer;
            end
        end
        // Hardware clear of irq enable wins over a same-cycle write
        if (timeout && wdEnableBit_ff) begin
            nxt_ie = 1'b0;
        end
        if (levelTwo || wdResetCauseFlag_ff) begin
            nxt_en = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    // Chip reset reloads defaults; enable then follows fuse and flag
    always @(posedge clk) begin
        if (!rst_n || chipReset) begin
            wdEnableBit_ff    <= 1'b0;
            wdIrqEnable_ff    <= 1'b0;
            wdPeriodSelect_ff <= 4'h0;
            wdTimeoutFlag_ff  <= 1'b0;
        end else begin
            wdEnableBit_ff    <= nxt_en;
            wdIrqEnable_ff    <= nxt_ie;
            wdPeriodSelect_ff <= nxt_per;
            // Set wins over write-one and acknowledge
            if (timeout && wdIrqEnable_ff) begin
                wdTimeoutFlag_ff <= 1'b1;
            end else if ((wrCtrl && pwdata[`WDTRF_C_FLAG]) || wdIrqAck) begin
                wdTimeoutFlag_ff <= 1'b0;
            end
        end
    end

    // Unlock window: set by writing unlock and enable together
    always @(posedge clk) begin
        if (!rst_n || chipReset) begin
            wdChangeUnlock_ff <= 1'b0;
            unlockCnt_ff      <= 3'h0;
        end else if (wrCtrl && pwdata[`WDTRF_C_UNLOCK] && pwdata[`WDTRF_C_EN]) begin
            wdChangeUnlock_ff <= 1'b1;
            unlockCnt_ff      <= `WDTRF_UNLOCK_CYC;
        end else if (wrCtrl || unlockCnt_ff == 3'h1) begin
            wdChangeUnlock_ff <= 1'b0;
            unlockCnt_ff      <= 3'h0;
        end else if (unlockCnt_ff != 3'h0) begin
            unlockCnt_ff      <= unlockCnt_ff - 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // Reset pulse
    // ----------------------------------------------------------------
    // Reset mode: enable set and irq enable clear
    always @(posedge clk) begin
        if (!rst_n) begin
            wdResetPulse_ff <= 1'b0;
        end else begin
            wdResetPulse_ff <= timeout && wdEnableBit_ff && !wdIrqEnable_ff;
        end
    end

    // Interrupt request, gated by both enables
    assign wdIrq = wdTimeoutFlag_ff && wdIrqEnable_ff && globalIrqEnable;

    // ----------------------------------------------------------------
    // Reset-cause flags
    // ----------------------------------------------------------------
    // Causes win over software clears; power-on clears the others
    always @(posedge clk) begin
        if (!rst_n) begin
            wdResetCauseFlag_ff  <= 1'b0;
            brownoutCauseFlag_ff <= 1'b0;
            externalCauseFlag_ff <= 1'b0;
            poweronCauseFlag_ff  <= 1'b1;
        end else if (poweronReset) begin
            wdResetCauseFlag_ff  <= 1'b0;
            brownoutCauseFlag_ff <= 1'b0;
            externalCauseFlag_ff <= 1'b0;
            poweronCauseFlag_ff  <= 1'b1;
        end else begin
            if (wdResetPulse_ff) begin
                wdResetCauseFlag_ff <= 1'b1;
            end else if (wrStat && !pwdata[`WDTRF_S_WDR]) begin
                wdResetCauseFlag_ff <= 1'b0;
            end
            if (brownoutReset) begin
                brownoutCauseFlag_ff <= 1'b1;
            end else if (wrStat && !pwdata[`WDTRF_S_BOR]) begin
                brownoutCauseFlag_ff <= 1'b0;
            end
            if (externalReset) begin
                externalCauseFlag_ff <= 1'b1;
            end else if (wrStat && !pwdata[`WDTRF_S_EXT]) begin
                externalCauseFlag_ff <= 1'b0;
            end
            if (wrStat && !pwdata[`WDTRF_S_POR]) begin
                poweronCauseFlag_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    assign enRead = wdEnableBit_ff || levelTwo;

    // Read data registered from the setup cycle so it stands in the access phase
    always @(posedge clk) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `WDTRF_CTRL_ADDR: prdata <= {24'h0, wdTimeoutFlag_ff, wdIrqEnable_ff,
                    wdPeriodSelect_ff[3], wdChangeUnlock_ff, enRead,
                    wdPeriodSelect_ff[2:0]};
                `WDTRF_STAT_ADDR: prdata <= {28'h0, wdResetCauseFlag_ff,
                    brownoutCauseFlag_ff, externalCauseFlag_ff, poweronCauseFlag_ff};
                `WDTRF_STRAP_ADDR: prdata <= {31'h0, levelTwo};
                default: prdata <= 32'h0;
            endcase
        end
    end
endmodule // wdtrf_top

//--- inc/wdtrf_consts.vh
// Constants for the watchdog timer with reset-cause flags.
// Assumes 20 MHz system clock and a 32-bit APB register port.
`ifndef WDTRF_CONSTS_VH
`define WDTRF_CONSTS_VH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define WDTRF_CTRL_IDX      8'h21
`define WDTRF_CTRL_ADDR     12'h084
`define WDTRF_STAT_ADDR     12'h088
`define WDTRF_STRAP_ADDR    12'h08c

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define WDTRF_C_FLAG        7
`define WDTRF_C_IE          6
`define WDTRF_C_P3          5
`define WDTRF_C_UNLOCK      4
`define WDTRF_C_EN          3

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define WDTRF_S_WDR         3
`define WDTRF_S_BOR         2
`define WDTRF_S_EXT         1
`define WDTRF_S_POR         0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WDTRF_UNLOCK_CYC    3'h4
`define WDTRF_OSC_HZ        128000
`define WDTRF_SYS_HZ        20000000
`define WDTRF_PER_MAX       4'h9
`define WDTRF_BASE_LOG2     11

`endif

//--- src/wdtrf_osc_tick.v
// Divider standing in for the 128 kHz on-chip watchdog oscillator.
// Assumes a free-running system clock; emits one tick per oscillator cycle.
`timescale 1ns/100ps
`include "wdtrf_consts.vh"

module wdtrf_osc_tick #(
    parameter integer SYS_HZ = `WDTRF_SYS_HZ,
    parameter integer OSC_HZ = `WDTRF_OSC_HZ
) (
    input  wire clk,
    input  wire rst_n,
    output reg  tick_ff
);
    // ----------------------------------------------------------------
    // Fractional accumulator
    // ----------------------------------------------------------------
    // Accumulator keeps the mean rate exact although 20 MHz / 128 kHz is not whole
    reg  [31:0] acc_ff;
    reg  [31:0] nxt_acc;
    reg         nxt_tick;

    always @* begin
        nxt_acc  = acc_ff + OSC_HZ;
        nxt_tick = 1'b0;
        if (nxt_acc >= SYS_HZ) begin
            nxt_acc  = nxt_acc - SYS_HZ;
            nxt_tick = 1'b1;
        end
    end

    // Registers
    always @(posedge clk) begin
        if (!rst_n) begin
            acc_ff  <= 32'h0;
            tick_ff <= 1'b0;
        end else begin
            acc_ff  <= nxt_acc;
            tick_ff <= nxt_tick;
        end
    end
endmodule // wdtrf_osc_tick

//--- src/wdtrf_counter.v
// Watchdog count and time-out detection on oscillator ticks.
// Assumes tick is a one-cycle pulse in the system clock domain.
`timescale 1ns/100ps
`include "wdtrf_consts.vh"

module wdtrf_counter #(
    parameter integer CNT_W = 21
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       tick,
    input  wire       clear,
    input  wire       run,
    input  wire [3:0] periodSel,
    output reg        timeout_ff
);
    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    reg  [CNT_W-1:0] cnt_ff;
    wire [3:0]       effSel;
    wire [CNT_W-1:0] limit;

    // Reserved codes fall back to the longest valid period
    assign effSel = (periodSel > `WDTRF_PER_MAX) ? `WDTRF_PER_MAX : periodSel;
    assign limit  = {{(CNT_W-1){1'b0}}, 1'b1} << (effSel + `WDTRF_BASE_LOG2);

    // Count ticks; a time-out restarts from zero
    always @(posedge clk) begin
        if (!rst_n || clear || !run) begin
            cnt_ff     <= {CNT_W{1'b0}};
            timeout_ff <= 1'b0;
        end else if (tick && (cnt_ff + 1'b1 >= limit)) begin
            cnt_ff     <= {CNT_W{1'b0}};
            timeout_ff <= 1'b1;
        end else begin
            cnt_ff     <= tick ? cnt_ff + 1'b1 : cnt_ff;
            timeout_ff <= 1'b0;
        end
    end
endmodule // wdtrf_counter

//--- testbench/wdtrf_properties.sv
// Port-level checker for the watchdog block.
// Bound to wdtrf_top; sees only its ports, one clock domain.
`timescale 1ns/100ps
`include "wdtrf_consts.vh"
module wdtrf_properties (
    input wire        clk,
    input wire        rst_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire        wdAlwaysOnFuse,
    input wire        wdRestartInstruction,
    input wire        globalIrqEnable,
    input wire        wdIrqAck,
    input wire        wdResetPulse_ff,
    input wire        wdIrq
);
    // --------
    // Decode
    // --------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Read access phase and address decode
    wire isCtrl = (paddr == `WDTRF_CTRL_ADDR);
    wire isStat = (paddr == `WDTRF_STAT_ADDR);
    wire mapped = isCtrl || isStat || (paddr == `WDTRF_STRAP_ADDR);
    wire rdAcc  = psel && penable && !pwrite;
    // --------
    // Properties
    // --------
    property p_pulseOne; wdResetPulse_ff |=> !wdResetPulse_ff [*8]; endproperty
    a_pulseOne: assert property (p_pulseOne)
        else $error("watchdog reset pulse too long");
    property p_restart; wdRestartInstruction |-> ##2 !wdResetPulse_ff [*8]; endproperty
    a_restart: assert property (p_restart)
        else $error("reset pulse right after restart");
    property p_irqGate; wdIrq |-> globalIrqEnable; endproperty
    a_irqGate: assert property (p_irqGate)
        else $error("interrupt without global enable");
    property p_ackClr; wdIrqAck |=> !wdIrq; endproperty
    a_ackClr: assert property (p_ackClr)
        else $error("interrupt stays after acknowledge");
    property p_errResp; psel && penable |-> (pslverr == !mapped); endproperty
    a_errResp: assert property (p_errResp)
        else $error("error response wrong for address");
    property p_unmapRd; rdAcc && !mapped |-> (prdata == 32'h0); endproperty
    a_unmapRd: assert property (p_unmapRd)
        else $error("unmapped read not zero");
    property p_statRsv; rdAcc && isStat |-> (prdata[31:4] == 28'h0); endproperty
    a_statRsv: assert property (p_statRsv)
        else $error("status reserved bits not zero");
    property p_ctrlHi; rdAcc && isCtrl |-> (prdata[31:8] == 24'h0); endproperty
    a_ctrlHi: assert property (p_ctrlHi)
        else $error("control upper bits not zero");
    property p_lvlTwo; wdAlwaysOnFuse [*6] ##0 (rdAcc && isCtrl) |-> prdata[3]; endproperty
    a_lvlTwo: assert property (p_lvlTwo)
        else $error("enable reads zero at level two");
    // Main scenarios reached
    c_pulse: cover property (wdResetPulse_ff);
    c_irq: cover property (wdIrq);
    c_err: cover property (pslverr);
endmodule // wdtrf_properties

bind wdtrf_top wdtrf_properties chk (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .prdata, .pslverr, .wdAlwaysOnFuse, .wdRestartInstruction, .globalIrqEnable,
    .wdIrqAck, .wdResetPulse_ff, .wdIrq);

//--- testbench/test_watchdog_timer_with_reset_flags.sv
// Self-checking bench for the watchdog block.
// Drives APB and reset causes itself; oscillator runs one tick per clock.
`timescale 1ns/100ps
`include "wdtrf_consts.vh"
module test_watchdog_timer_with_reset_flags;
    localparam [11:0] CA = `WDTRF_CTRL_ADDR;
    localparam [11:0] SA = `WDTRF_STAT_ADDR;
    reg         clk = 1'h0;
    reg         rst_n = 1'h0;
    reg         psel = 1'h0;
    reg         penable = 1'h0;
    reg         pwrite = 1'h0;
    reg  [11:0] paddr = 12'h0;
    reg  [31:0] pwdata = 32'h0;
    reg         fuse = 1'h0;
    reg         irqOn = 1'h0;
    reg  [4:0]  pulses = 5'h0;
    wire        pready;
    wire [31:0] prdata;
    wire        pslverr;
    wire        wdPulse;
    wire        wdIrq;
    reg  [31:0] tbl [0:16];
    reg  [31:0] got;
    integer     fail_count = 0;
    integer     check_count = 0;
    integer     cycles = 0;
    integer     i;
    integer     n;

    // Equal rates give one oscillator tick per clock, so periods stay short
    wdtrf_top #(.SYS_HZ(20000000), .OSC_HZ(20000000)) uut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .wdAlwaysOnFuse(fuse), .wdRestartInstruction(pulses[3]),
        .globalIrqEnable(irqOn), .wdIrqAck(pulses[4]), .poweronReset(pulses[0]),
        .brownoutReset(pulses[2]), .externalReset(pulses[1]),
        .wdResetPulse_ff(wdPulse), .wdIrq(wdIrq));

    // Clock and hang guard
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            end_of_test;
        end
    end

    task end_of_test;
        begin
            if (fail_count == 0 && check_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    task chk(input [31:0] g, input [31:0] e);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk);
            psel <= 1'h1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'h1;
            @(posedge clk);
            while (pready !== 1'h1) @(posedge clk);
            got = prdata;
            psel <= 1'h0;
            penable <= 1'h0;
        end
    endtask

    task wr(input [11:0] a, input [7:0] d);
        apb(1'h1, a, {24'h0, d});
    endtask

    task rd(input [11:0] a, input [7:0] e);
        begin
            apb(1'h0, a, 32'h0);
            chk(got, {24'h0, e});
        end
    endtask

    // One-cycle strobe on reset causes, restart or acknowledge
    task strobe(input [4:0] p);
        begin
            @(posedge clk) pulses <= p;
            @(posedge clk) pulses <= 5'h0;
        end
    endtask

    initial begin
        // Rows: write flag, address, data or expected read, idle cycles before
        tbl[0] = {4'h0, SA, 8'h01, 8'h0};
        tbl[1] = {4'h0, CA, 8'h00, 8'h0};
        tbl[2] = {4'h1, SA, 8'h00, 8'h0};
        tbl[3] = {4'h0, SA, 8'h00, 8'h0};
        tbl[4] = {4'h1, CA, 8'h07, 8'h0};
        tbl[5] = {4'h0, CA, 8'h07, 8'h0};
        tbl[6] = {4'h1, CA, 8'h08, 8'h0};
        tbl[7] = {4'h0, CA, 8'h08, 8'h0};
        tbl[8] = {4'h1, CA, 8'h00, 8'h0};
        tbl[9] = {4'h0, CA, 8'h08, 8'h0};
        tbl[10] = {4'h1, CA, 8'h18, 8'h0};
        tbl[11] = {4'h1, CA, 8'h00, 8'h0};
        tbl[12] = {4'h0, CA, 8'h00, 8'h0};
        tbl[13] = {4'h1, CA, 8'h18, 8'h0};
        tbl[14] = {4'h1, CA, 8'h00, 8'h5};
        tbl[15] = {4'h0, CA, 8'h08, 8'h0};
        tbl[16] = {4'h0, 12'h090, 8'h00, 8'h0};
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        for (i = 0; i < 17; i = i + 1) begin
            repeat (tbl[i][7:0]) @(posedge clk);
            if (tbl[i][28])
                wr(tbl[i][27:16], tbl[i][15:8]);
            else
                rd(tbl[i][27:16], tbl[i][15:8]);
        end
        // Interrupt-only mode, gating and acknowledge
        irqOn <= 1'h1;
        wr(CA, 8'h18);
        wr(CA, 8'h40);
        while (wdIrq !== 1'h1) @(negedge clk);
        chk({31'h0, wdIrq}, 32'h1);
        @(posedge clk) irqOn <= 1'h0;
        @(negedge clk) chk({31'h0, wdIrq}, 32'h0);
        @(posedge clk) irqOn <= 1'h1;
        strobe(5'h10);
        @(negedge clk) chk({31'h0, wdIrq}, 32'h0);
        // Interrupt then reset: first time-out drops irq enable
        wr(CA, 8'h48);
        strobe(5'h08);
        repeat (2100) @(posedge clk);
        rd(CA, 8'h88);
        wr(CA, 8'h88);
        rd(CA, 8'h08);
        strobe(5'h08);
        n = 0;
        while (wdPulse !== 1'h1) begin
            @(negedge clk);
            n = n + 1;
        end
        chk({31'h0, (n >= 2040) && (n <= 2060)}, 32'h1);
        rd(SA, 8'h08);
        rd(CA, 8'h08);
        wr(CA, 8'h18);
        wr(CA, 8'h00);
        rd(CA, 8'h08);
        wr(SA, 8'h00);
        wr(CA, 8'h18);
        wr(CA, 8'h00);
        rd(CA, 8'h00);
        // Other reset causes
        strobe(5'h02);
        rd(SA, 8'h02);
        strobe(5'h04);
        rd(SA, 8'h06);
        strobe(5'h01);
        rd(SA, 8'h01);
        // Safety level two
        @(posedge clk) fuse <= 1'h1;
        repeat (4) @(posedge clk);
        rd(CA, 8'h08);
        wr(CA, 8'h18);
        wr(CA, 8'h00);
        rd(CA, 8'h08);
        wr(CA, 8'h09);
        rd(CA, 8'h08);
        wr(CA, 8'h18);
        wr(CA, 8'h01);
        rd(CA, 8'h09);
        // Reset again in mid-run
        @(posedge clk) rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        rd(SA, 8'h01);
        rd(CA, 8'h08);
        end_of_test;
    end
endmodule // test_watchdog_timer_with_reset_flags
